// File: src/gll_top.sv
`timescale 1ns/100ps
`default_nettype none

`include "gll_defs.svh"

module gll_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  // plain gpio settings from the rest of the device
  input wire logic [15:0] gpio_data,
  input wire logic [15:0] gpio_oe,
  // pins
  input wire logic [15:0] io_in,
  output logic [15:0] io_out,
  output logic [15:0] io_oe,
  // status
  output logic [15:0] lookup_active
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  gll_pkg::gll_byte_t upper_lookup_mode_q;
  gll_pkg::gll_byte_t lower_lookup_mode_q;
  gll_pkg::gll_byte_t upper_two_input_truth_table_q;
  gll_pkg::gll_byte_t lower_two_input_truth_table_q;
  gll_pkg::gll_byte_t upper_three_input_truth_table_q;
  gll_pkg::gll_byte_t upper_dual_output_table_first_q;
  gll_pkg::gll_byte_t upper_dual_output_table_second_q;
  gll_pkg::gll_byte_t upper_high_three_input_table_q;
  gll_pkg::gll_byte_t lower_three_input_truth_table_q;
  gll_pkg::gll_byte_t lower_dual_output_table_first_q;
  gll_pkg::gll_byte_t lower_dual_output_table_second_q;
  gll_pkg::gll_byte_t lower_high_three_input_table_q;
  logic [7:0] rdata_d;
  logic hit_d;
  logic [7:0] reg_rdata_q;
  logic reg_rvalid_q;
  logic [15:0] io_out_q;
  logic [15:0] io_oe_q;
  logic [15:0] io_out_d;
  logic [15:0] io_oe_d;
  logic [15:0] look_drv;
  logic [15:0] look_val;
  logic [15:0] lookup_active_q;

  function automatic logic wr_at(input logic [7:0] addr);
    wr_at = reg_wr && (reg_addr == addr);
  endfunction : wr_at

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_lookup_mode_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_UPPER_MODE)) begin
      upper_lookup_mode_q <= reg_wdata & `GLL_MODE_WMASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lower_lookup_mode_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_LOWER_MODE)) begin
      lower_lookup_mode_q <= reg_wdata & `GLL_MODE_WMASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_two_input_truth_table_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_UPPER_TWO)) begin
      upper_two_input_truth_table_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lower_two_input_truth_table_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_LOWER_TWO)) begin
      lower_two_input_truth_table_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_three_input_truth_table_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_UPPER_THREE)) begin
      upper_three_input_truth_table_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_dual_output_table_first_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_UPPER_DUAL_A)) begin
      upper_dual_output_table_first_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_dual_output_table_second_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_UPPER_DUAL_B)) begin
      upper_dual_output_table_second_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_high_three_input_table_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_UPPER_HI_THREE)) begin
      upper_high_three_input_table_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lower_three_input_truth_table_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_LOWER_THREE)) begin
      lower_three_input_truth_table_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lower_dual_output_table_first_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_LOWER_DUAL_A)) begin
      lower_dual_output_table_first_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lower_dual_output_table_second_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_LOWER_DUAL_B)) begin
      lower_dual_output_table_second_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lower_high_three_input_table_q <= `GLL_RESET_BYTE;
    end else if (wr_at(`GLL_ADDR_LOWER_HI_THREE)) begin
      lower_high_three_input_table_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    hit_d = 1'b1;
    case (reg_addr)
      `GLL_ADDR_UPPER_MODE: rdata_d = upper_lookup_mode_q;
      `GLL_ADDR_LOWER_MODE: rdata_d = lower_lookup_mode_q;
      `GLL_ADDR_UPPER_TWO: rdata_d = upper_two_input_truth_table_q;
      `GLL_ADDR_LOWER_TWO: rdata_d = lower_two_input_truth_table_q;
      `GLL_ADDR_UPPER_THREE: rdata_d = upper_three_input_truth_table_q;
      `GLL_ADDR_UPPER_DUAL_A: rdata_d = upper_dual_output_table_first_q;
      `GLL_ADDR_UPPER_DUAL_B: rdata_d = upper_dual_output_table_second_q;
      `GLL_ADDR_UPPER_HI_THREE: rdata_d = upper_high_three_input_table_q;
      `GLL_ADDR_LOWER_THREE: rdata_d = lower_three_input_truth_table_q;
      `GLL_ADDR_LOWER_DUAL_A: rdata_d = lower_dual_output_table_first_q;
      `GLL_ADDR_LOWER_DUAL_B: rdata_d = lower_dual_output_table_second_q;
      `GLL_ADDR_LOWER_HI_THREE: rdata_d = lower_high_three_input_table_q;
      default: begin
        rdata_d = 8'h00;
        hit_d = 1'b0;
      end
    endcase
  end

  assign reg_hit = hit_d;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= `GLL_RESET_BYTE;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign reg_rvalid = reg_rvalid_q;

  // ----------------------------------------------------------------
  // mode decode, the reserved high field code 3 falls back to gpio
  // ----------------------------------------------------------------
  function automatic gll_pkg::gll_mode_t high_mode(input logic [1:0] f);
    if (f == `GLL_MODE_DUAL) begin
      high_mode = gll_pkg::GLL_GPIO;
    end else begin
      high_mode = gll_pkg::gll_mode_t'(f);
    end
  endfunction : high_mode

  gll_nib_if u_hi ();
  gll_nib_if u_lo ();
  gll_nib_if l_hi ();
  gll_nib_if l_lo ();

  // upper bank, high nibble I/O[15:12]
  assign u_hi.mode = high_mode(upper_lookup_mode_q[`GLL_HI_MSB:`GLL_HI_LSB]);
  assign u_hi.pins = io_in[15:12];
  assign u_hi.tab_two = upper_two_input_truth_table_q[`GLL_TWO_HI_MSB:`GLL_TWO_HI_LSB];
  assign u_hi.tab_three = upper_high_three_input_table_q;
  assign u_hi.tab_dual_a = 8'h00;
  assign u_hi.tab_dual_b = 8'h00;

  // upper bank, low nibble I/O[11:8]
  assign u_lo.mode = gll_pkg::gll_mode_t'(upper_lookup_mode_q[`GLL_LO_MSB:`GLL_LO_LSB]);
  assign u_lo.pins = io_in[11:8];
  assign u_lo.tab_two = upper_two_input_truth_table_q[`GLL_TWO_LO_MSB:`GLL_TWO_LO_LSB];
  assign u_lo.tab_three = upper_three_input_truth_table_q;
  assign u_lo.tab_dual_a = upper_dual_output_table_first_q;
  assign u_lo.tab_dual_b = upper_dual_output_table_second_q;

  // lower bank, high nibble I/O[7:4]
  assign l_hi.mode = high_mode(lower_lookup_mode_q[`GLL_HI_MSB:`GLL_HI_LSB]);
  assign l_hi.pins = io_in[7:4];
  assign l_hi.tab_two = lower_two_input_truth_table_q[`GLL_TWO_HI_MSB:`GLL_TWO_HI_LSB];
  assign l_hi.tab_three = lower_high_three_input_table_q;
  assign l_hi.tab_dual_a = 8'h00;
  assign l_hi.tab_dual_b = 8'h00;

  // lower bank, low nibble I/O[3:0]
  assign l_lo.mode = gll_pkg::gll_mode_t'(lower_lookup_mode_q[`GLL_LO_MSB:`GLL_LO_LSB]);
  assign l_lo.pins = io_in[3:0];
  assign l_lo.tab_two = lower_two_input_truth_table_q[`GLL_TWO_LO_MSB:`GLL_TWO_LO_LSB];
  assign l_lo.tab_three = lower_three_input_truth_table_q;
  assign l_lo.tab_dual_a = lower_dual_output_table_first_q;
  assign l_lo.tab_dual_b = lower_dual_output_table_second_q;

  gll_nibble u_nib_uhi (
    .nib(u_hi.engine)
  );

  gll_nibble u_nib_ulo (
    .nib(u_lo.engine)
  );

  gll_nibble u_nib_lhi (
    .nib(l_hi.engine)
  );

  gll_nibble u_nib_llo (
    .nib(l_lo.engine)
  );

  // ----------------------------------------------------------------
  // merge; the dual mode of a low nibble reaches into the next nibble
  // ----------------------------------------------------------------
  assign look_drv = {u_hi.drv[3:0], 4'h0, l_hi.drv[3:0], 4'h0}
                  | {3'h0, u_lo.drv, 3'h0, l_lo.drv};
  assign look_val = {u_hi.val[3:0], 4'h0, l_hi.val[3:0], 4'h0}
                  | {3'h0, u_lo.val, 3'h0, l_lo.val};

  always_comb begin
    io_out_d = gpio_data;
    io_oe_d = gpio_oe;
    for (int i = 0; i < 16; i++) begin
      if (look_drv[i]) begin
        io_out_d[i] = look_val[i];
        io_oe_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_out_q <= `GLL_RESET_WORD;
      io_oe_q <= `GLL_RESET_WORD;
    end else begin
      io_out_q <= io_out_d;
      io_oe_q <= io_oe_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lookup_active_q <= `GLL_RESET_WORD;
    end else begin
      lookup_active_q <= look_drv;
    end
  end

  assign io_out = io_out_q;
  assign io_oe = io_oe_q;
  assign lookup_active = lookup_active_q;

endmodule : gll_top

`default_nettype wire

// File: src/gll_defs.svh
`ifndef GLL_DEFS_SVH
`define GLL_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define GLL_ADDR_UPPER_MODE 8'h20
`define GLL_ADDR_LOWER_MODE 8'h21
`define GLL_ADDR_UPPER_TWO 8'h22
`define GLL_ADDR_LOWER_TWO 8'h23
`define GLL_ADDR_UPPER_THREE 8'h24
`define GLL_ADDR_UPPER_DUAL_A 8'h25
`define GLL_ADDR_UPPER_DUAL_B 8'h26
`define GLL_ADDR_UPPER_HI_THREE 8'h27
`define GLL_ADDR_LOWER_THREE 8'h28
`define GLL_ADDR_LOWER_DUAL_A 8'h29
`define GLL_ADDR_LOWER_DUAL_B 8'h2A
`define GLL_ADDR_LOWER_HI_THREE 8'h2B

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define GLL_RESET_BYTE 8'h00
`define GLL_RESET_WORD 16'h0000
`define GLL_MODE_WMASK 8'h33
`define GLL_HI_MSB 5
`define GLL_HI_LSB 4
`define GLL_LO_MSB 1
`define GLL_LO_LSB 0
`define GLL_TWO_HI_MSB 7
`define GLL_TWO_HI_LSB 4
`define GLL_TWO_LO_MSB 3
`define GLL_TWO_LO_LSB 0
`define GLL_MODE_GPIO 2'h0
`define GLL_MODE_TWO 2'h1
`define GLL_MODE_THREE 2'h2
`define GLL_MODE_DUAL 2'h3
`define GLL_BIT_TWO 2
`define GLL_BIT_THREE 3
`define GLL_BIT_DUAL 4

`endif

// File: src/gll_pkg.sv
`include "gll_defs.svh"

package gll_pkg;

  typedef enum logic [1:0] {
    GLL_GPIO = `GLL_MODE_GPIO,
    GLL_TWO = `GLL_MODE_TWO,
    GLL_THREE = `GLL_MODE_THREE,
    GLL_DUAL = `GLL_MODE_DUAL
  } gll_mode_t;

  typedef logic [7:0] gll_byte_t;

  // ----------------------------------------------------------------
  // table lookups
  // ----------------------------------------------------------------
  function automatic logic gll_lut2(input logic [3:0] tab, input logic [1:0] idx);
    gll_lut2 = tab[idx];
  endfunction : gll_lut2

  function automatic logic gll_lut3(input logic [7:0] tab, input logic [2:0] idx);
    gll_lut3 = tab[idx];
  endfunction : gll_lut3

endpackage : gll_pkg

// File: src/gll_nib_if.sv
`timescale 1ns/100ps
`default_nettype none

interface gll_nib_if;
  gll_pkg::gll_mode_t mode;
  logic [3:0] pins;
  logic [3:0] tab_two;
  logic [7:0] tab_three;
  logic [7:0] tab_dual_a;
  logic [7:0] tab_dual_b;
  logic [4:0] drv;
  logic [4:0] val;

  modport engine (
    input mode, pins, tab_two, tab_three, tab_dual_a, tab_dual_b,
    output drv, val
  );
  modport ctrl (
    output mode, pins, tab_two, tab_three, tab_dual_a, tab_dual_b,
    input drv, val
  );
endinterface : gll_nib_if

`default_nettype wire

// File: src/gll_nibble.sv
`timescale 1ns/100ps
`default_nettype none

`include "gll_defs.svh"

module gll_nibble (
  gll_nib_if.engine nib
);

  // ----------------------------------------------------------------
  // per-nibble lookup engine
  // ----------------------------------------------------------------
  always_comb begin
    nib.drv = 5'h00;
    nib.val = 5'h00;
    case (nib.mode)
      gll_pkg::GLL_TWO: begin
        nib.drv[`GLL_BIT_TWO] = 1'b1;
        nib.val[`GLL_BIT_TWO] = gll_pkg::gll_lut2(nib.tab_two, nib.pins[1:0]);
      end
      gll_pkg::GLL_THREE: begin
        nib.drv[`GLL_BIT_THREE] = 1'b1;
        nib.val[`GLL_BIT_THREE] = gll_pkg::gll_lut3(nib.tab_three, nib.pins[2:0]);
      end
      gll_pkg::GLL_DUAL: begin
        nib.drv[`GLL_BIT_THREE] = 1'b1;
        nib.drv[`GLL_BIT_DUAL] = 1'b1;
        nib.val[`GLL_BIT_THREE] = gll_pkg::gll_lut3(nib.tab_dual_a, nib.pins[2:0]);
        nib.val[`GLL_BIT_DUAL] = gll_pkg::gll_lut3(nib.tab_dual_b, nib.pins[2:0]);
      end
      default: begin
        nib.drv = 5'h00;
        nib.val = 5'h00;
      end
    endcase
  end

endmodule : gll_nibble

`default_nettype wire

// File: dv/gll_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

module gll_pin_model (
  // device side
  input wire logic [15:0] io_out,
  input wire logic [15:0] io_oe,
  // external drivers
  input wire logic [15:0] ext_val,
  // pin levels
  output logic [15:0] io_in
);
  // device wins where it drives, else the external part
  assign io_in = (io_out & io_oe) | (ext_val & ~io_oe);
endmodule : gll_pin_model

`default_nettype wire

// File: dv/gll_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module gll_top_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit,
  // gpio and pins
  input wire logic [15:0] gpio_data,
  input wire logic [15:0] gpio_oe,
  input wire logic [15:0] io_in,
  input wire logic [15:0] io_out,
  input wire logic [15:0] io_oe,
  input wire logic [15:0] lookup_active
);
  logic [7:0] um_q, lm_q, ut_q, lt_q;
  logic [15:0] la_q;
  logic [3:0] lut_q;

  // shadow of modes and two-input tables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      um_q <= 8'h00;
      lm_q <= 8'h00;
      ut_q <= 8'h00;
      lt_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'h20) um_q <= reg_wdata & 8'h33;
      if (reg_addr == 8'h21) lm_q <= reg_wdata & 8'h33;
      if (reg_addr == 8'h22) ut_q <= reg_wdata;
      if (reg_addr == 8'h23) lt_q <= reg_wdata;
    end
  end

  // expected lookup pins and values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      la_q <= 16'h0000;
      lut_q <= 4'h0;
    end else begin
      la_q <= {um_q[5:4] == 2'h2, um_q[5:4] == 2'h1, 1'b0, um_q[1:0] == 2'h3, um_q[1],
               um_q[1:0] == 2'h1, 2'b00, lm_q[5:4] == 2'h2, lm_q[5:4] == 2'h1, 1'b0,
               lm_q[1:0] == 2'h3, lm_q[1], lm_q[1:0] == 2'h1, 2'b00};
      lut_q <= {ut_q[{1'b1, io_in[13:12]}], ut_q[{1'b0, io_in[9:8]}],
                lt_q[{1'b1, io_in[5:4]}], lt_q[{1'b0, io_in[1:0]}]};
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence mode_rd_s;
    reg_rd && reg_addr == 8'h20;
  endsequence

  gpio_pass_a: assert property (
    1'b1 |=> ((io_out ^ $past(gpio_data)) & ~lookup_active) == 16'h0000)
    else $error("plain pin value differs from gpio data");
  pin_enable_a: assert property (
    1'b1 |=> (((io_oe ^ $past(gpio_oe)) & ~lookup_active) | (lookup_active & ~io_oe)) == 16'h0000)
    else $error("pin enable wrong");
  upper_high_sel_a: assert property (lookup_active[15:12] == la_q[15:12])
    else $error("upper high lookup pins wrong");
  upper_low_sel_a: assert property (lookup_active[11:8] == la_q[11:8])
    else $error("upper low lookup pins wrong");
  lower_high_sel_a: assert property (lookup_active[7:4] == la_q[7:4])
    else $error("lower high lookup pins wrong");
  lower_low_sel_a: assert property (lookup_active[3:0] == la_q[3:0])
    else $error("lower low lookup pins wrong");
  upper_two_val_a: assert property (lookup_active[14] |-> io_out[14] == lut_q[3])
    else $error("pin 14 lookup value wrong");
  upper_low_val_a: assert property (lookup_active[10] |-> io_out[10] == lut_q[2])
    else $error("pin 10 lookup value wrong");
  lower_high_val_a: assert property (lookup_active[6] |-> io_out[6] == lut_q[1])
    else $error("pin 6 lookup value wrong");
  lower_two_val_a: assert property (lookup_active[2] |-> io_out[2] == lut_q[0])
    else $error("pin 2 lookup value wrong");
  mode_read_a: assert property (mode_rd_s |=> reg_rvalid && reg_rdata == $past(um_q))
    else $error("mode readback wrong");
  unmapped_read_a: assert property (reg_rd && !reg_hit |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : gll_top_assertions

bind gll_top gll_top_assertions chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .gpio_data(gpio_data), .gpio_oe(gpio_oe),
  .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .lookup_active(lookup_active));

`default_nettype wire

// File: dv/gpio_lookup_logic_mode_test.sv
`timescale 1ns/100ps
`default_nettype none

module gpio_lookup_logic_mode_test;
  logic clk, rst, reg_wr, reg_rd, reg_hit, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] gpio_data, gpio_oe, io_in, io_out, io_oe, lookup_active, ext_val;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  gll_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .gpio_data(gpio_data), .gpio_oe(gpio_oe), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .lookup_active(lookup_active));
  gll_pin_model pins (.io_out(io_out), .io_oe(io_oe), .ext_val(ext_val), .io_in(io_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // one idle edge so the next strobe never follows in the same step
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    chk("rdata", {7'h00, 1'b1, exp}, {7'h00, reg_rvalid, reg_rdata});
    @(posedge clk);
    #1;
  endtask : rd

  // walk every index of one lookup pin
  task automatic scan(input string name, input int pin, input int lsb, input int n,
      input logic [7:0] tab, input int ofs);
    for (int i = 0; i < (1 << n); i++) begin
      ext_val = (ext_val & ~(((16'h1 << n) - 16'h1) << lsb)) | (16'(i) << lsb);
      @(posedge clk);
      #1;
      chk(name, {14'h0, 1'b1, tab[ofs + i]}, {14'h0, io_oe[pin], io_out[pin]});
    end
  endtask : scan

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int a = 8'h20; a <= 8'h2B; a++) rd(8'(a), 8'h00);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    chk("hit", 16'h0000, {15'h0, reg_hit});
    // reserved bits and the reserved high code are never written
    wr(8'h20, 8'h12);
    rd(8'h20, 8'h12);
    wr(8'h21, 8'h21);
    rd(8'h21, 8'h21);
  endtask : t_reset

  task automatic t_gpio;
    gpio_oe = 16'hF0F0;
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h00);
    @(posedge clk);
    #1;
    chk("io_out", gpio_data, io_out);
    chk("io_oe", 16'hF0F0, io_oe);
    chk("active", 16'h0000, lookup_active);
    gpio_oe = 16'h0000;
    @(posedge clk);
    #1;
    chk("io_oe off", 16'h0000, io_oe);
  endtask : t_gpio

  task automatic t_upper_high;
    wr(8'h22, 8'hA0);
    wr(8'h20, 8'h10);
    scan("io14", 14, 12, 2, 8'hA0, 4);
    wr(8'h22, 8'h50);
    scan("io14 new", 14, 12, 2, 8'h50, 4);
    wr(8'h20, 8'h00);
    @(posedge clk);
    #1;
    chk("io14 plain", {15'h0, gpio_data[14]}, {15'h0, io_out[14]});
    wr(8'h27, 8'h96);
    wr(8'h20, 8'h20);
    scan("io15", 15, 12, 3, 8'h96, 0);
    chk("io14 idle", {15'h0, gpio_data[14]}, {15'h0, io_out[14]});
  endtask : t_upper_high

  task automatic t_upper_low;
    wr(8'h22, 8'h06);
    wr(8'h20, 8'h01);
    scan("io10", 10, 8, 2, 8'h06, 0);
    wr(8'h24, 8'h3C);
    wr(8'h20, 8'h02);
    scan("io11", 11, 8, 3, 8'h3C, 0);
    wr(8'h25, 8'hE1);
    wr(8'h26, 8'h4B);
    wr(8'h20, 8'h03);
    scan("io11 dual", 11, 8, 3, 8'hE1, 0);
    scan("io12 dual", 12, 8, 3, 8'h4B, 0);
    wr(8'h20, 8'h00);
  endtask : t_upper_low

  task automatic t_lower;
    wr(8'h23, 8'h9C);
    wr(8'h21, 8'h11);
    scan("io6", 6, 4, 2, 8'h9C, 4);
    scan("io2", 2, 0, 2, 8'h9C, 0);
    wr(8'h2B, 8'h69);
    wr(8'h28, 8'hD2);
    wr(8'h21, 8'h22);
    scan("io7", 7, 4, 3, 8'h69, 0);
    scan("io3", 3, 0, 3, 8'hD2, 0);
    wr(8'h29, 8'h87);
    wr(8'h2A, 8'h5E);
    wr(8'h21, 8'h03);
    scan("io3 dual", 3, 0, 3, 8'h87, 0);
    scan("io4 dual", 4, 0, 3, 8'h5E, 0);
    rd(8'h21, 8'h03);
  endtask : t_lower

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      finish_test;
    end
  end

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    gpio_data = 16'h5A3C;
    gpio_oe = 16'h0000;
    ext_val = 16'h0000;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_gpio;
    t_upper_high;
    t_upper_low;
    t_lower;
    finish_test;
  end
endmodule : gpio_lookup_logic_mode_test

`default_nettype wire
